// ==== rtl/byte_exec_params.svh ====
// byte_exec_params.svh: encodings, field positions and reset values
// assumes inclusion by bare name from rtl/ sources
`ifndef BYTE_EXEC_PARAMS_SVH
`define BYTE_EXEC_PARAMS_SVH

`define SET_ALL_ONES_OPC 7'h34
`define ROTATE_RIGHT_NOCARRY_OPC 6'h10
`define ALL_ONES_VALUE 8'hff
`define LITERAL_OFFSET_MAX 8'h5f
`define ACCESS_BIT_POS 8
`define DEST_BIT_POS 9
`define QUICK_BANK_SPLIT 8'h80
`define QUICK_BANK_HIGH 4'hf
`define QUICK_BANK_LOW 4'h0
`define WREG_RESET 8'h00
`define BANK_SELECT_RESET 4'h0
`define FILE_ADDR_RESET 12'h000

`endif

// ==== rtl/byte_exec_pkg.sv ====
// byte_exec_pkg: shared types of the byte execution block
// assumes nothing beyond a SystemVerilog compiler
package byte_exec_pkg;
  typedef logic [11:0] data_addr_t;
  typedef logic [7:0] byte_t;
  typedef enum logic [1:0] {
    op_none,
    op_set_all_ones,
    op_rotate_right
  } op_kind_e;
endpackage

// ==== rtl/data_memory.sv ====
// data_memory: 4096-byte data store, registered read data
// assumes one read and one write port on the core clock
`timescale 1ns/100ps
`default_nettype none
module data_memory
  import byte_exec_pkg::*;
(
  input wire logic clk,
  input wire data_addr_t rd_addr,
  output byte_t rd_data,
  input wire logic wr_en,
  input wire data_addr_t wr_addr,
  input wire byte_t wr_data
);
  byte_t mem [0:4095];

  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge clk) begin
    rd_data <= mem[rd_addr];
  end
endmodule // data_memory
`default_nettype wire

// ==== rtl/byte_exec.sv ====
// byte_exec: executes set-all-ones and rotate-right-no-carry
// assumes one instruction word offered per valid pulse, core clock
//
// Behaviour
// - set-all-ones writes ffh into the file register; flags untouched.
// - access bit 0 selects quick-access bank, bank select ignored.
// - access bit 1 forms address from bank select and file field.
// - access 0, extended set, field <= 5fh uses indexed literal offset.
// - rotate with destination 0 writes working register, file kept.
// - rotate right one place, bit 0 into bit 7, no carry.
// - destination 0 writes working register, 1 the file register.
`timescale 1ns/100ps
`default_nettype none
`include "byte_exec_params.svh"
module byte_exec
  import byte_exec_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic instr_valid,
  input wire logic [15:0] instr_word,
  input wire logic [3:0] bank_select_reg,
  input wire logic extended_set_en,
  input wire logic [11:0] index_base,
  output logic [7:0] wreg_q,
  output logic busy_q,
  output logic done_q,
  output logic illegal_q,
  output logic file_write_q,
  output logic [11:0] file_addr_q
);
  // ----------------------------------------
  // decode and address formation
  // ----------------------------------------
  op_kind_e kind_d, kind_q;
  data_addr_t addr_d;
  logic dest_d, dest_q;
  logic access_bit;
  logic [7:0] field;

  logic is_set;
  logic is_rotate;
  logic literal_window;

  data_addr_t banked_addr;
  data_addr_t quick_addr;
  data_addr_t indexed_addr;

  byte_t rd_data;
  byte_t rotated;
  byte_t result;
  logic mem_we;

  // c0 takes the word, c1 reads the operand, c2 shows the outcome
  assign access_bit = instr_word[`ACCESS_BIT_POS];
  assign field = instr_word[7:0];
  assign is_set = instr_word[15:9] == `SET_ALL_ONES_OPC;
  assign is_rotate = instr_word[15:10] == `ROTATE_RIGHT_NOCARRY_OPC;

  // anything else decodes to none: reported, never executed
  always_comb begin
    kind_d = op_none;
    dest_d = 1'b1;
    if (is_set) begin
      kind_d = op_set_all_ones;
    end else if (is_rotate) begin
      kind_d = op_rotate_right;
      dest_d = instr_word[`DEST_BIT_POS];
    end
  end

  // ----------------------------------------
  // address formation
  // ----------------------------------------
  // bank select only matters when the access bit is set
  assign banked_addr = {bank_select_reg, field};
  // wraps at the top of data space; no carry beyond twelve bits
  assign indexed_addr = index_base + {4'h0, field};
  // the literal window only replaces quick-bank style accesses
  assign literal_window = extended_set_en && field <= `LITERAL_OFFSET_MAX;

  // low half of the quick bank is bank 0, upper half the top bank
  always_comb begin
    if (field >= `QUICK_BANK_SPLIT) begin
      quick_addr = {`QUICK_BANK_HIGH, field};
    end else begin
      quick_addr = {`QUICK_BANK_LOW, field};
    end
  end

  always_comb begin
    if (access_bit) begin
      addr_d = banked_addr;
    end else if (literal_window) begin
      addr_d = indexed_addr;
    end else begin
      addr_d = quick_addr;
    end
  end

  // ----------------------------------------
  // read phase: one cycle to fetch the operand
  // ----------------------------------------
  // busy only for decodable words, so an illegal one writes nothing
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      busy_q <= 1'b0;
    end else begin
      busy_q <= instr_valid && kind_d != op_none;
    end
  end

  // kind, destination and address held between words for write back
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      kind_q <= op_none;
    end else if (instr_valid) begin
      kind_q <= kind_d;
    end
  end

  // set-all-ones always lands in the file
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      dest_q <= 1'b0;
    end else if (instr_valid) begin
      dest_q <= dest_d;
    end
  end

  // captured so write back need not keep the word on the input
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      file_addr_q <= `FILE_ADDR_RESET;
    end else if (instr_valid) begin
      file_addr_q <= addr_d;
    end
  end

  // ----------------------------------------
  // operand store
  // ----------------------------------------
  // no forwarding: a read right after a write to one byte sees old data
  // the store is read every cycle; only the captured address is written
  data_memory u_mem (
    .clk(clk),
    .rd_addr(addr_d),
    .rd_data(rd_data),
    .wr_en(mem_we),
    .wr_addr(file_addr_q),
    .wr_data(result)
  );

  // ----------------------------------------
  // process
  // ----------------------------------------
  // rotation is pure wiring; no carry bit takes part
  // one tap per bit keeps the bit order explicit
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_rot
      assign rotated[gi] = rd_data[(gi + 1) % 8];
    end
  endgenerate

  // set-all-ones ignores the operand read in c1
  always_comb begin
    if (kind_q == op_set_all_ones) begin
      result = `ALL_ONES_VALUE;
    end else begin
      result = rotated;
    end
  end

  // ----------------------------------------
  // write back
  // ----------------------------------------
  // set-all-ones always targets the file; flags live elsewhere, untouched
  assign mem_we = busy_q && dest_q;

  // only rotates aimed at the working register change it
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      wreg_q <= `WREG_RESET;
    end else if (busy_q && !dest_q) begin
      wreg_q <= result;
    end
  end

  // ----------------------------------------
  // report
  // ----------------------------------------
  // one-cycle pulses; a caller that looks late misses them
  // done marks the end of every legal word
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      done_q <= 1'b0;
    end else begin
      done_q <= busy_q;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      file_write_q <= 1'b0;
    end else begin
      file_write_q <= mem_we;
    end
  end

  // flags an unknown word; the core decides what to do with it
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      illegal_q <= 1'b0;
    end else begin
      illegal_q <= instr_valid && kind_d == op_none;
    end
  end
endmodule // byte_exec
`default_nettype wire

// ==== rtl/byte_exec_end.sv ====
// spare: intentionally empty unit
`timescale 1ns/100ps

// ==== tb/byte_exec_monitor.sv ====
// byte_exec_monitor: port assertions for byte_exec
// assumes byte_exec_params.svh on the include path
`timescale 1ns/100ps
`default_nettype none
`include "byte_exec_params.svh"
module byte_exec_monitor (
  input wire logic clk,
  input wire logic reset,
  input wire logic instr_valid,
  input wire logic [15:0] instr_word,
  input wire logic [3:0] bank_select_reg,
  input wire logic extended_set_en,
  input wire logic [11:0] index_base,
  input wire logic [7:0] wreg_q,
  input wire logic busy_q,
  input wire logic done_q,
  input wire logic illegal_q,
  input wire logic file_write_q,
  input wire logic [11:0] file_addr_q
);
  // ----------------
  // decode
  // ----------------
  wire logic [7:0] f = instr_word[7:0];
  wire logic acc = instr_word[`ACCESS_BIT_POS];
  wire logic dst = instr_word[`DEST_BIT_POS];
  wire logic set_v = instr_valid && instr_word[15:9] == `SET_ALL_ONES_OPC;
  wire logic rot_v = instr_valid &&
    instr_word[15:10] == `ROTATE_RIGHT_NOCARRY_OPC;
  wire logic lv = set_v || rot_v;
  wire logic idx = !acc && extended_set_en && f <= `LITERAL_OFFSET_MAX;
  wire logic [11:0] quick_a = {f[7] ? `QUICK_BANK_HIGH : `QUICK_BANK_LOW, f};
  wire logic [11:0] idx_a = index_base + {4'h0, f};
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  AST_LEGAL_DONE: assert property (lv |-> ##1 busy_q ##1 done_q)
    else $error("legal op not done in two cycles");
  AST_SET_WRITE: assert property (set_v |-> ##2 file_write_q)
    else $error("set op did not write file");
  AST_ROT_W: assert property (rot_v && !dst |-> ##2 !file_write_q)
    else $error("rotate to w wrote file");
  AST_ROT_F: assert property (rot_v && dst |-> ##2 file_write_q)
    else $error("rotate to f did not write file");
  AST_BANKED: assert property (lv && acc |=>
    file_addr_q == {$past(bank_select_reg), $past(f)})
    else $error("banked address wrong");
  AST_QUICK: assert property (lv && !acc && !idx |=>
    file_addr_q == $past(quick_a)) else $error("quick address wrong");
  AST_INDEX: assert property (lv && idx |=>
    file_addr_q == $past(idx_a)) else $error("indexed address wrong");
  AST_ILLEGAL: assert property (instr_valid && !lv |->
    ##1 illegal_q ##1 !file_write_q) else $error("illegal op mishandled");
endmodule // byte_exec_monitor
bind byte_exec byte_exec_monitor i_mon (
  .clk(clk), .reset(reset), .instr_valid(instr_valid),
  .instr_word(instr_word), .bank_select_reg(bank_select_reg),
  .extended_set_en(extended_set_en), .index_base(index_base),
  .wreg_q(wreg_q), .busy_q(busy_q), .done_q(done_q),
  .illegal_q(illegal_q), .file_write_q(file_write_q),
  .file_addr_q(file_addr_q)
);
`default_nettype wire

// ==== tb/set_byte_and_rotate_exec_tb.sv ====
// set_byte_and_rotate_exec_tb: random self-checking bench for byte_exec
// assumes byte_exec_pkg compiled first
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, g) begin n_tests++; if ((g) !== (e)) begin \
  num_errors++; $display("CHECK FAILED %s exp %h got %h", n, e, g); end end
module set_byte_and_rotate_exec_tb;
  import byte_exec_pkg::*;
  logic clk = 0;
  logic reset = 1;
  logic instr_valid = 0;
  logic extended_set_en = 0;
  logic [15:0] instr_word = 0;
  logic [3:0] bank_select_reg = 0;
  logic [11:0] index_base = 0;
  logic a;
  logic [7:0] f;
  wire logic [7:0] wreg_q;
  wire logic busy_q, done_q, illegal_q, file_write_q;
  wire logic [11:0] file_addr_q;
  int num_errors = 0;
  int n_tests = 0;
  byte_exec i_dut (
    .clk(clk), .reset(reset), .instr_valid(instr_valid),
    .instr_word(instr_word), .bank_select_reg(bank_select_reg),
    .extended_set_en(extended_set_en), .index_base(index_base),
    .wreg_q(wreg_q), .busy_q(busy_q), .done_q(done_q),
    .illegal_q(illegal_q), .file_write_q(file_write_q),
    .file_addr_q(file_addr_q)
  );
  initial begin forever #2.5 clk = ~clk; end
  initial begin #50000; num_errors++; end_sim; end
  function automatic data_addr_t exp_addr(logic [15:0] w);
    if (w[8]) return {bank_select_reg, w[7:0]};
    if (extended_set_en && w[7:0] <= 8'h5f) return index_base + w[7:0];
    return {w[7] ? 4'hf : 4'h0, w[7:0]};
  endfunction
  function automatic byte_t exp_rot(byte_t v);
    return {v[0], v[7:1]};
  endfunction
  task automatic issue(input logic [15:0] w);
    @(posedge clk); #1 instr_valid = 1; instr_word = w;
    @(posedge clk); #1 instr_valid = 0;
  endtask
  task automatic op(input logic [15:0] w, input logic fw);
    issue(w);
    `CHK("addr", exp_addr(w), file_addr_q)
    @(posedge clk); #1;
    `CHK("done", 1'b1, done_q)
    `CHK("fwrite", fw, file_write_q)
  endtask
  task automatic end_sim;
    $display("errors %0d checks %0d", num_errors, n_tests);
    if (num_errors == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    void'($urandom(32'h0f1b501a));
    repeat (12) @(posedge clk);
    #1 reset = 0;
    // edge of the literal offset window first, then random
    for (int i = 0; i < 40; i++) begin
      f = i < 4 ? 8'h5e + i[7:0] : 8'($urandom);
      a = i < 4 ? 1'b0 : 1'($urandom);
      extended_set_en = i < 4 ? 1'b1 : 1'($urandom);
      bank_select_reg = 4'($urandom);
      index_base = 12'($urandom);
      op({7'h34, a, f}, 1'b1);
      op({6'h10, 1'b0, a, f}, 1'b0);
      `CHK("wreg", exp_rot(8'hff), wreg_q)
      op({6'h10, 1'b1, a, f}, 1'b1);
    end
    issue(16'hffff);
    `CHK("illegal", 1'b1, illegal_q)
    end_sim;
  end
endmodule // set_byte_and_rotate_exec_tb
`default_nettype wire
